// *** src/temp_limit_defines.svh ***
`ifndef TEMP_LIMIT_DEFINES_SVH
`define TEMP_LIMIT_DEFINES_SVH

// register byte offsets
`define REG_CTRL          8'h00
`define REG_LEVEL         8'h04
`define REG_CYCLE         8'h08
`define REG_STATUS        8'h0C
`define REG_IRQ_STAT      8'h10
`define REG_IRQ_MASK      8'h14
`define REG_THRESH        8'h18
`define REG_MEAS          8'h1C

// control register fields
`define CTRL_ON_CHANGE    0
`define CTRL_EXT_LSB      1
`define CTRL_MODE_LSB     4
`define CTRL_HYST_LSB     8
`define CTRL_ON_DLY_LSB   12
`define CTRL_OFF_DLY_LSB  16

// reset values
`define RST_ON_CHANGE     1'h1
`define RST_MODE          4'h0
`define RST_HYST          4'h0
`define RST_DLY           4'h0
`define RST_CYCLE         8'h00
`define RST_LEVEL         8'h14
`define RST_IRQ_MASK      3'h0

// legal codes and limits
`define MODE_LAST         4'hB
`define HYST_LAST         4'h8
`define DLY_LAST          4'hD
`define LEVEL_MIN         8'hF1
`define LEVEL_MAX         8'h32
`define PCT_FULL          8'h64
`define PCT_ZERO_DECI     16'h00C8
`define DECI_PER_DEG      16'h000A

// irq bits
`define IRQ_CHANGE        0
`define IRQ_SENT          1
`define IRQ_EXT           2

// timing
`define CLK_HZ            10000000
`define TICK_S            1
`define TICK_CYCLES       (`CLK_HZ * `TICK_S)
`define CYCLE_UNIT_S      10

`endif

// *** src/temp_limit_pkg.sv ***
`default_nettype none
package temp_limit_pkg;

  typedef enum logic [1:0] {
    EXT_NONE = 2'b00,
    EXT_WORD = 2'b01,
    EXT_BYTE = 2'b10
  } ext_sel_e;

  typedef struct packed {
    logic               ack;
    logic        [31:0] rdata;
    logic               on_change;
    ext_sel_e           ext;
    logic        [3:0]  mode;
    logic        [3:0]  hyst;
    logic        [3:0]  on_dly;
    logic        [3:0]  off_dly;
    logic        [7:0]  cycle;
    logic signed [7:0]  level;
    logic               ext_ok;
    logic signed [15:0] ext_thr;
    logic               raw;
    logic               acc;
    logic        [23:0] dpre;
    logic        [11:0] dsec;
    logic        [23:0] cpre;
    logic        [11:0] csec;
    logic               send;
    logic               send_val;
    logic        [2:0]  irq_st;
    logic        [2:0]  irq_msk;
  } mon_s;

endpackage : temp_limit_pkg
`default_nettype wire

// *** src/temperature_limit_monitor.sv ***
// Overview of operation
// - configured threshold is clamped to the span -15 to +50 degC.
// - hysteresis none,1,2,3,4,5,10,15,20 K offsets the reverse crossing.
// - downward-release modes: above threshold sets, below threshold-hyst clears; polarity selectable.
// - upward-release modes: below threshold sets, above threshold+hyst clears; polarity selectable.
// - four modes act only on threshold crossing, silent on the hysteresis crossing.
// - four modes silent on threshold crossing, act only on the hysteresis crossing.
// - threshold comes from bus as 16-bit or 8-bit value, else configured one.
// - switch-on delay none,1,3,5,10,15,30 s or 1,3,5,10,15,30,60 min.
// - a change to one is accepted only after switch-on delay; cyclic keeps zero.
// - a change to zero is accepted only after switch-off delay; cyclic keeps one.
// - a condition with no telegram also suppresses cyclic sends while it holds.
// - send-on-change transmits each accepted zero-to-one or one-to-zero change, except while a condition with no telegram holds.
// - without send-on-change a nonzero cycle still transmits periodically.
// - cyclic interval is the cycle setting times ten seconds.
// - cycle setting zero disables periodic transmission.
// - no send-on-change and cycle zero means the object is never sent.
// - 8-bit external threshold is percent: 0 % is -20 degC, 100 % is 55 degC.
// - result is a one-bit object sent on change and/or cyclically.
`include "temp_limit_defines.svh"
`default_nettype none
module temperature_limit_monitor #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] temp_value,
  input  wire logic [15:0] ext_thr_value,
  input  wire logic        ext_thr_write,
  output logic             limit_state,
  output logic             telegram_send,
  output logic             telegram_value,
  output logic             irq
);

  localparam logic [23:0] TICK_LAST  = 24'(TICK_CYCLES - 1);
  localparam logic [11:0] CYC_UNIT   = 12'(`CYCLE_UNIT_S);

  temp_limit_pkg::mon_s state_ff;
  temp_limit_pkg::mon_s nxt_state;

  logic signed [16:0] thr;
  logic signed [16:0] hyst_d;
  logic signed [16:0] meas;
  logic               upward;
  logic               p_cond;
  logic               s_cond;
  logic               p_act;
  logic               s_act;
  logic               suppress;
  logic               wr_go;
  logic        [11:0] target;
  logic        [11:0] cyc_len;
  logic               cyc_fire;
  logic               chg_fire;
  logic        [7:0]  pct;
  logic        [10:0] pct15;
  logic signed [7:0]  wlevel;
  logic        [3:0]  wcode;

  // hysteresis code to tenths of a kelvin
  function automatic logic [15:0] hyst_deci(input logic [3:0] code);
    case (code)
      4'h1:    hyst_deci = 16'h000A;
      4'h2:    hyst_deci = 16'h0014;
      4'h3:    hyst_deci = 16'h001E;
      4'h4:    hyst_deci = 16'h0028;
      4'h5:    hyst_deci = 16'h0032;
      4'h6:    hyst_deci = 16'h0064;
      4'h7:    hyst_deci = 16'h0096;
      4'h8:    hyst_deci = 16'h00C8;
      default: hyst_deci = 16'h0000;
    endcase
  endfunction : hyst_deci

  // delay code to seconds
  function automatic logic [11:0] dly_sec(input logic [3:0] code);
    case (code)
      4'h1:    dly_sec = 12'h001;
      4'h2:    dly_sec = 12'h003;
      4'h3:    dly_sec = 12'h005;
      4'h4:    dly_sec = 12'h00A;
      4'h5:    dly_sec = 12'h00F;
      4'h6:    dly_sec = 12'h01E;
      4'h7:    dly_sec = 12'h03C;
      4'h8:    dly_sec = 12'h0B4;
      4'h9:    dly_sec = 12'h12C;
      4'hA:    dly_sec = 12'h258;
      4'hB:    dly_sec = 12'h384;
      4'hC:    dly_sec = 12'h708;
      4'hD:    dly_sec = 12'hE10;
      default: dly_sec = 12'h000;
    endcase
  endfunction : dly_sec

  always_comb begin
    nxt_state = state_ff;
    meas      = 17'(signed'(temp_value));
    // external value only counts once one has arrived after selection
    if (state_ff.ext != temp_limit_pkg::EXT_NONE && state_ff.ext_ok) begin
      thr = 17'(state_ff.ext_thr);
    end else begin
      thr = 17'(signed'(16'(state_ff.level) * signed'(`DECI_PER_DEG)));
    end
    hyst_d   = 17'(signed'(hyst_deci(state_ff.hyst)));
    // mode bit 1 clear: trips on rising through threshold
    upward   = ~state_ff.mode[1];
    p_cond   = upward ? (meas > thr) : (meas < thr);
    s_cond   = upward ? (meas < thr - hyst_d) : (meas > thr + hyst_d);
    p_act    = state_ff.mode < 4'h8;
    s_act    = (state_ff.mode < 4'h4) || (state_ff.mode > 4'h7);
    suppress = (p_cond & ~p_act) | (s_cond & ~s_act);
    // set level: even modes 0 to 6 drive ON on the threshold crossing
    if (p_cond && p_act) begin
      nxt_state.raw = ~state_ff.mode[0];
    end else if (s_cond && s_act) begin
      nxt_state.raw = state_ff.mode[0];
    end

    // delay timers; prescaler restarts with each pending change
    target = state_ff.raw ? dly_sec(state_ff.on_dly) : dly_sec(state_ff.off_dly);
    if (state_ff.raw == state_ff.acc) begin
      nxt_state.dpre = 24'h000000;
      nxt_state.dsec = 12'h000;
    end else if (state_ff.dsec >= target) begin
      nxt_state.acc  = state_ff.raw;
      nxt_state.dpre = 24'h000000;
      nxt_state.dsec = 12'h000;
    end else if (state_ff.dpre == TICK_LAST) begin
      nxt_state.dpre = 24'h000000;
      nxt_state.dsec = state_ff.dsec + 12'h001;
    end else begin
      nxt_state.dpre = state_ff.dpre + 24'h000001;
    end

    // cyclic interval counter
    cyc_len  = 12'(state_ff.cycle) * CYC_UNIT;
    cyc_fire = 1'b0;
    if (state_ff.cycle == 8'h00) begin
      nxt_state.cpre = 24'h000000;
      nxt_state.csec = 12'h000;
    end else if (state_ff.cpre == TICK_LAST) begin
      nxt_state.cpre = 24'h000000;
      if (state_ff.csec + 12'h001 >= cyc_len) begin
        nxt_state.csec = 12'h000;
        cyc_fire       = 1'b1;
      end else begin
        nxt_state.csec = state_ff.csec + 12'h001;
      end
    end else begin
      nxt_state.cpre = state_ff.cpre + 24'h000001;
    end

    // telegrams carry the accepted value, not the raw one
    chg_fire           = state_ff.on_change && (nxt_state.acc != state_ff.acc);
    nxt_state.send     = (chg_fire | cyc_fire) & ~suppress;
    // value only moves with a send, so it stands between telegrams
    if (nxt_state.send) begin
      nxt_state.send_val = nxt_state.acc;
    end

    // external threshold object
    pct   = (ext_thr_value[7:0] > `PCT_FULL) ? `PCT_FULL : ext_thr_value[7:0];
    pct15 = 11'(pct) * 11'h00F;
    if (ext_thr_write && state_ff.ext == temp_limit_pkg::EXT_WORD) begin
      nxt_state.ext_thr = signed'(ext_thr_value);
      nxt_state.ext_ok  = 1'b1;
    end else if (ext_thr_write && state_ff.ext == temp_limit_pkg::EXT_BYTE) begin
      // 7.5 tenths per percent, rounded down
      nxt_state.ext_thr = signed'(16'(pct15 >> 1) - `PCT_ZERO_DECI);
      nxt_state.ext_ok  = 1'b1;
    end

    // bus: one wait cycle, read data captured on the first edge
    nxt_state.ack = (avs_read | avs_write) & ~state_ff.ack;
    wr_go         = avs_write & state_ff.ack;
    if (avs_read && !state_ff.ack) begin
      if (avs_address == `REG_CTRL) begin
        nxt_state.rdata = {12'h000, state_ff.off_dly, state_ff.on_dly, state_ff.hyst,
                           state_ff.mode, 1'b0, state_ff.ext, state_ff.on_change};
      end else if (avs_address == `REG_LEVEL) begin
        nxt_state.rdata = {24'h000000, state_ff.level};
      end else if (avs_address == `REG_CYCLE) begin
        nxt_state.rdata = {24'h000000, state_ff.cycle};
      end else if (avs_address == `REG_STATUS) begin
        nxt_state.rdata = {26'h0000000, state_ff.ext_ok, suppress,
                           state_ff.raw & ~state_ff.acc, ~state_ff.raw & state_ff.acc,
                           state_ff.raw, state_ff.acc};
      end else if (avs_address == `REG_IRQ_STAT) begin
        nxt_state.rdata = {29'h00000000, state_ff.irq_st};
      end else if (avs_address == `REG_IRQ_MASK) begin
        nxt_state.rdata = {29'h00000000, state_ff.irq_msk};
      end else if (avs_address == `REG_THRESH) begin
        nxt_state.rdata = {{16{thr[15]}}, 16'(thr)};
      end else if (avs_address == `REG_MEAS) begin
        nxt_state.rdata = {{16{temp_value[15]}}, temp_value};
      end else begin
        nxt_state.rdata = 32'h00000000;
      end
    end

    wlevel = signed'(avs_writedata[7:0]);
    wcode  = 4'h0;
    if (wr_go) begin
      if (avs_address == `REG_CTRL) begin
        nxt_state.on_change = avs_writedata[`CTRL_ON_CHANGE];
        if (avs_writedata[`CTRL_EXT_LSB +: 2] != 2'b11) begin
          nxt_state.ext = temp_limit_pkg::ext_sel_e'(avs_writedata[`CTRL_EXT_LSB +: 2]);
          // a new source choice drops any old external value
          if (nxt_state.ext != state_ff.ext) begin
            nxt_state.ext_ok = 1'b0;
          end
        end
        wcode = avs_writedata[`CTRL_MODE_LSB +: 4];
        if (wcode <= `MODE_LAST) begin
          nxt_state.mode = wcode;
        end
        wcode = avs_writedata[`CTRL_HYST_LSB +: 4];
        if (wcode <= `HYST_LAST) begin
          nxt_state.hyst = wcode;
        end
        wcode = avs_writedata[`CTRL_ON_DLY_LSB +: 4];
        if (wcode <= `DLY_LAST) begin
          nxt_state.on_dly = wcode;
        end
        wcode = avs_writedata[`CTRL_OFF_DLY_LSB +: 4];
        if (wcode <= `DLY_LAST) begin
          nxt_state.off_dly = wcode;
        end
      end else if (avs_address == `REG_LEVEL) begin
        if (wlevel < signed'(`LEVEL_MIN)) begin
          nxt_state.level = signed'(`LEVEL_MIN);
        end else if (wlevel > signed'(`LEVEL_MAX)) begin
          nxt_state.level = signed'(`LEVEL_MAX);
        end else begin
          nxt_state.level = wlevel;
        end
      end else if (avs_address == `REG_CYCLE) begin
        nxt_state.cycle = avs_writedata[7:0];
        nxt_state.cpre  = 24'h000000;
        nxt_state.csec  = 12'h000;
      end else if (avs_address == `REG_IRQ_MASK) begin
        nxt_state.irq_msk = avs_writedata[2:0];
      end
    end

    // sticky events; a set in the clearing cycle wins
    nxt_state.irq_st = state_ff.irq_st;
    if (wr_go && avs_address == `REG_IRQ_STAT) begin
      nxt_state.irq_st = state_ff.irq_st & ~avs_writedata[2:0];
    end
    nxt_state.irq_st[`IRQ_CHANGE] = nxt_state.irq_st[`IRQ_CHANGE]
                                    | (nxt_state.acc != state_ff.acc);
    nxt_state.irq_st[`IRQ_SENT]   = nxt_state.irq_st[`IRQ_SENT] | nxt_state.send;
    nxt_state.irq_st[`IRQ_EXT]    = nxt_state.irq_st[`IRQ_EXT]
                                    | (ext_thr_write && state_ff.ext != temp_limit_pkg::EXT_NONE);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff           <= '0;
      state_ff.on_change <= `RST_ON_CHANGE;
      state_ff.ext       <= temp_limit_pkg::EXT_NONE;
      state_ff.mode      <= `RST_MODE;
      state_ff.hyst      <= `RST_HYST;
      state_ff.on_dly    <= `RST_DLY;
      state_ff.off_dly   <= `RST_DLY;
      state_ff.cycle     <= `RST_CYCLE;
      state_ff.level     <= `RST_LEVEL;
      state_ff.irq_msk   <= `RST_IRQ_MASK;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~state_ff.ack;
  assign avs_readdata    = state_ff.rdata;
  assign limit_state     = state_ff.acc;
  assign telegram_send   = state_ff.send;
  assign telegram_value  = state_ff.send_val;
  assign irq             = |(state_ff.irq_st & state_ff.irq_msk);

endmodule : temperature_limit_monitor
`default_nettype wire

// *** dv/temp_limit_props.sv ***
`default_nettype none
module temp_limit_props #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] temp_value,
  input wire logic [15:0] ext_thr_value,
  input wire logic        ext_thr_write,
  input wire logic        limit_state,
  input wire logic        telegram_send,
  input wire logic        telegram_value,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire req = avs_read | avs_write;
  AST_WREQ_RISE: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  AST_WREQ_IDLE: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  AST_WREQ_ONE: assert property (req && !avs_waitrequest |=> !req || avs_waitrequest)
    else $error("waitrequest low two cycles");
  AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("readdata moved without a read");
  AST_TG_VAL: assert property (telegram_send |-> telegram_value == limit_state)
    else $error("telegram value differs from state");
  AST_TG_HOLD: assert property ($changed(telegram_value) |-> telegram_send)
    else $error("telegram value moved without a send");
  AST_TG_PULSE: assert property (telegram_send |=> !telegram_send)
    else $error("telegram pulse longer than one cycle");
  AST_RST_CLEAR: assert property ($fell(reset) |-> !limit_state && !telegram_send && !irq)
    else $error("outputs not cleared by reset");
  cover property (telegram_send && telegram_value);
  cover property ($rose(irq));
  cover property ($fell(limit_state));
endmodule : temp_limit_props
bind temperature_limit_monitor temp_limit_props #(.TICK_CYCLES(TICK_CYCLES)) props_i (
  .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .temp_value(temp_value), .irq(irq),
  .ext_thr_value(ext_thr_value), .ext_thr_write(ext_thr_write), .limit_state(limit_state),
  .telegram_send(telegram_send), .telegram_value(telegram_value));
`default_nettype wire

// *** dv/bus_model.sv ***
`default_nettype none
module bus_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        telegram_send,
  input  wire logic        telegram_value,
  output logic      [15:0] ext_thr_value,
  output logic             ext_thr_write
);
  timeunit 1ns;
  timeprecision 1ns;
  int   tcount;
  logic last_value;
  initial begin
    tcount = 0;
    last_value = 1'b0;
    ext_thr_value = 16'h0000;
    ext_thr_write = 1'b0;
  end
  // counts survive bench resets so tests take differences
  always @(posedge clk) begin
    if (telegram_send && !reset) begin
      tcount <= tcount + 1;
      last_value <= telegram_value;
    end
  end
  // inverted after the pulse so a stale value cannot pass
  task automatic send_thr(input logic [15:0] v);
    @(posedge clk);
    ext_thr_value <= v;
    ext_thr_write <= 1'b1;
    @(posedge clk);
    ext_thr_value <= ~v;
    ext_thr_write <= 1'b0;
  endtask : send_thr
endmodule : bus_model
`default_nettype wire

// *** dv/tb_temperature_limit_monitor.sv ***
`include "temp_limit_defines.svh"
`default_nettype none
module tb_temperature_limit_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, avs_read, avs_write, ext_thr_write;
  logic        limit_state, telegram_send, telegram_value, irq, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] temp_value, ext_thr_value;
  int          bad_count, tests_run, n0, ne;
  logic        e, nv, trip;
  logic [15:0] tt [4] = '{16'h00D2, 16'h00BE, 16'h00B9, 16'h00D7};
  logic [15:0] hk [9] = '{16'h0, 16'hA, 16'h14, 16'h1E, 16'h28, 16'h32, 16'h64, 16'h96, 16'hC8};
  logic [7:0]  ra [5] = '{`REG_CTRL, `REG_LEVEL, `REG_CYCLE, `REG_IRQ_MASK, `REG_THRESH};
  logic [31:0] rv [5] = '{32'h1, 32'h14, 32'h0, 32'h0, 32'hC8};
  logic [15:0] pc [4] = '{16'h0, 16'h32, 16'h64, 16'hC8};
  logic [31:0] pt [4] = '{32'hFFFFFF38, 32'hAF, 32'h226, 32'h226};
  temperature_limit_monitor #(.TICK_CYCLES(10)) temperature_limit_monitor_i (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .temp_value(temp_value), .irq(irq),
    .ext_thr_value(ext_thr_value), .ext_thr_write(ext_thr_write), .limit_state(limit_state),
    .telegram_send(telegram_send), .telegram_value(telegram_value));
  bus_model bus_model_i (.clk(clk), .reset(reset), .telegram_send(telegram_send),
    .telegram_value(telegram_value), .ext_thr_value(ext_thr_value),
    .ext_thr_write(ext_thr_write));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] ctl(logic oc, logic [1:0] x, logic [3:0] m, h, on, off);
    return {12'h000, off, on, h, m, 1'b0, x, oc};
  endfunction : ctl
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
      bad_count++;
    end
  endtask : chk
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    // values read right after the edge are those the design sampled
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // let the write settle before callers look at outputs
    @(negedge clk);
  endtask : bus
  task automatic step(input logic [15:0] t, input int n);
    @(posedge clk);
    temp_value <= t;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : step
  // neutral temperature first so the raw state wakes up clear
  task automatic do_reset();
    step(16'h00C8, 2);
    @(posedge clk);
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
  endtask : do_reset
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #3000000;
    bad_count++;
    complete_run();
  end
  initial begin
    {reset, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 42'h0};
    temp_value = 16'h00C8;
    bad_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(0, ra[i], 32'h0);
      chk("reset value", rv[i], q);
    end
    bus(0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1, `REG_LEVEL, 32'h64);
    bus(0, `REG_LEVEL, 32'h0);
    chk("level high", 32'h32, {24'h0, q[7:0]});
    bus(1, `REG_LEVEL, 32'hD8);
    bus(0, `REG_THRESH, 32'h0);
    chk("level low", 32'hFFFFFF6A, q);
    bus(1, `REG_LEVEL, 32'h14);
    for (int h = 0; h < 9; h++) begin
      bus(1, `REG_CTRL, ctl(1, 2'h0, 4'h0, 4'(h), 4'h0, 4'h0));
      step(16'h00D2, 4);
      chk("hyst set", 32'h1, {31'h0, limit_state});
      step(16'h00C9 - hk[h], 4);
      chk("hyst inside", 32'h1, {31'h0, limit_state});
      step(16'h00C7 - hk[h], 4);
      chk("hyst out", 32'h0, {31'h0, limit_state});
    end
    for (int m = 0; m < 12; m++) begin
      do_reset();
      bus(1, `REG_CTRL, ctl(1, 2'h0, 4'(m), 4'h1, 4'h0, 4'h0));
      e = 1'b0;
      ne = 0;
      n0 = bus_model_i.tcount;
      for (int k = 0; k < 4; k++) begin
        trip = (k % 2 == 0);
        step(tt[(trip ? 0 : 2) + m[1]], 4);
        if (trip ? m < 8 : (m < 4 || m > 7)) begin
          nv = trip ? ~m[0] : m[0];
          ne += (nv != e);
          e = nv;
        end
        chk("mode state", {31'h0, e}, {31'h0, limit_state});
      end
      chk("mode sends", 32'(ne), 32'(bus_model_i.tcount - n0));
    end
    do_reset();
    bus(1, `REG_IRQ_MASK, 32'h1);
    bus(1, `REG_CTRL, ctl(1, 2'h0, 4'h0, 4'h0, 4'h1, 4'h2));
    step(16'h00D2, 5);
    chk("on delay", 32'h0, {31'h0, limit_state});
    step(16'h00D2, 10);
    chk("on done", 32'h1, {31'h0, limit_state});
    chk("irq", 32'h1, {31'h0, irq});
    bus(0, `REG_STATUS, 32'h0);
    chk("status", 32'h3, q);
    bus(0, `REG_MEAS, 32'h0);
    chk("meas", 32'hD2, q);
    bus(1, `REG_IRQ_STAT, 32'h7);
    chk("irq clear", 32'h0, {31'h0, irq});
    step(16'h00BE, 20);
    chk("off delay", 32'h1, {31'h0, limit_state});
    step(16'h00BE, 15);
    chk("off done", 32'h0, {31'h0, limit_state});
    bus(1, `REG_IRQ_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1, `REG_CTRL, ctl(1, 2'h0, 4'h4, 4'h1, 4'h0, 4'h0));
    step(16'h00B9, 4);
    bus(1, `REG_CYCLE, 32'h1);
    n0 = bus_model_i.tcount;
    repeat (250) @(posedge clk);
    chk("suppressed", 32'h0, 32'(bus_model_i.tcount - n0));
    step(16'h00D2, 4);
    for (int c = 1; c >= 0; c--) begin
      bus(1, `REG_CTRL, ctl(0, 2'h0, 4'h0, 4'h0, 4'h0, 4'h0));
      bus(1, `REG_CYCLE, 32'(c));
      n0 = bus_model_i.tcount;
      repeat (350) @(posedge clk);
      chk("cyclic", 32'(3 * c), 32'(bus_model_i.tcount - n0));
    end
    chk("telegram value", 32'h1, {31'h0, bus_model_i.last_value});
    bus_model_i.send_thr(16'h00FA);
    bus(0, `REG_THRESH, 32'h0);
    chk("ext ignored", 32'hC8, q);
    bus(1, `REG_CTRL, ctl(1, 2'h1, 4'h0, 4'h0, 4'h0, 4'h0));
    bus_model_i.send_thr(16'h00FA);
    bus(0, `REG_THRESH, 32'h0);
    chk("ext word", 32'hFA, q);
    bus(1, `REG_CTRL, ctl(1, 2'h2, 4'h0, 4'h0, 4'h0, 4'h0));
    for (int p = 0; p < 4; p++) begin
      bus_model_i.send_thr(pc[p]);
      bus(0, `REG_THRESH, 32'h0);
      chk("ext pct", pt[p], q);
    end
    complete_run();
  end
endmodule : tb_temperature_limit_monitor
`default_nettype wire
